/* File: hw/retimer_pkg.sv */
/*
 * Shared constants and carrier types for the retimer channel controller.
 * Assumes a 20 MHz core clock and an 8-bit channel register port.
 */
package retimer_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ      = 20;
    localparam int SETTLE_NS    = 500;   // Score settling per table step.
    localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int LOCK_TMO_US  = 12;    // Wait for lock per attempt.
    localparam int LOCK_TMO_CYC = LOCK_TMO_US * CLK_MHZ;
    localparam int LOCK_TRIES   = 4;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int TAB_N  = 32;
    localparam int TAB_AW = 5;
    localparam int CW     = 6;           // Coarse tuning code width.
    localparam int CNT_W  = 16;          // Reference count width.
    localparam int TMR_W  = 8;
    localparam int TRY_W  = 3;
    localparam int NTAPS  = 5;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STAT   = 8'h01;
    localparam logic [7:0] OFF_EQIDX  = 8'h02;
    localparam logic [7:0] OFF_COARSE = 8'h03;
    localparam logic [7:0] OFF_RATE_L = 8'h04;
    localparam logic [7:0] OFF_RATE_H = 8'h05;
    localparam logic [7:0] OFF_SUB    = 8'h06;
    localparam logic [7:0] OFF_PPM_L  = 8'h07;
    localparam logic [7:0] OFF_PPM_H  = 8'h08;
    localparam logic [7:0] OFF_DIV    = 8'h09;
    localparam logic [7:0] OFF_VOD    = 8'h0a;
    localparam logic [7:0] OFF_DEEMPH = 8'h0b;
    localparam logic [7:0] OFF_TAP0   = 8'h10;
    localparam logic [7:0] OFF_EOM    = 8'h3e;
    localparam logic [7:0] OFF_TAB    = 8'h40;
    localparam logic [7:0] OFF_TAB_E  = 8'h5f;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int B_SD_OVR   = 0;       // Control: signal detect override.
    localparam int B_SD_VAL   = 1;       // Control: forced data path state.
    localparam int B_CDR_RST  = 2;       // Control: write 1, self clearing.
    localparam int B_READAPT  = 3;       // Control: write 1, self clearing.
    localparam int B_LIMIT    = 4;
    localparam int B_DFE_EN   = 5;
    localparam int B_MODE_HI  = 7;       // Adapt mode is bits 7:6.
    localparam int B_MANUAL   = 7;       // Subrate register: manual target.
    localparam int B_EOM_EN   = 7;
    localparam int B_TAP_POL  = 7;
    localparam logic [7:0] CTRL_WMASK = 8'hf3;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] TAB_RST    = 8'h00;
    localparam logic [7:0] TAP_MASK   = 8'h9f;
    localparam logic [7:0] RATE_DIV   = 8'h01;
    localparam logic       EOM_RST    = 1'b1;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       pol;
        logic [4:0] weight;
    } dfe_tap_t;

endpackage

/* File: hw/eq_list_mem.sv */
/*
 * Boost setting list storage: one write port, two registered read ports.
 * Assumes writes come from the register port and reads from the adaption
 * sequencer and register reads; all in the core clock domain.
 */
`timescale 1ns/10ps
module eq_list_mem
    import retimer_pkg::*;
#(
    parameter int N  = TAB_N,
    parameter int AW = TAB_AW,
    parameter int DW = 8
) (
    input  wire logic          clk,     // Core clock.
    input  wire logic          rstn,    // Asynchronous reset, active low.
    input  wire logic          ce,      // Clock enable.
    input  wire logic          wr_en,   // Write strobe.
    input  wire logic [AW-1:0] wr_addr, // Write entry.
    input  wire logic [DW-1:0] wr_data, // Write data.
    input  wire logic [AW-1:0] ra_addr, // Read port A entry.
    output logic      [DW-1:0] ra_data, // Read port A data, registered.
    input  wire logic [AW-1:0] rb_addr, // Read port B entry.
    output logic      [DW-1:0] rb_data  // Read port B data, registered.
);

    typedef struct packed {
        logic [N-1:0][DW-1:0] mem;
        logic [DW-1:0]        ra;
        logic [DW-1:0]        rb;
    } mem_st_t;

    mem_st_t s_q;
    mem_st_t s_d;

    // Reads see the old contents when written in the same cycle.
    always_comb begin
        s_d    = s_q;
        s_d.ra = s_q.mem[ra_addr];
        s_d.rb = s_q.mem[rb_addr];
        if (wr_en) begin
            s_d.mem[wr_addr] = wr_data;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= {(N + 2){DW'(TAB_RST)}};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign ra_data = s_q.ra;
    assign rb_data = s_q.rb;

endmodule // eq_list_mem

/* File: hw/chan_adapt_ctrl.sv */
/*
 * One retimer channel: signal detect gating, oscillator coarse calibration,
 * equalizer adaption over the boost setting list, lock qualification and
 * the channel register file. Four copies make the four-lane device.
 * Assumes the analog side supplies energy, lock, eye and score levels and a
 * reference counter that answers count_start with count_done.
 */
`timescale 1ns/10ps
module chan_adapt_ctrl
    import retimer_pkg::*;
#(
    parameter int TRIES = LOCK_TRIES
) (
    input  wire logic             clk,         // Core clock, 20 MHz.
    input  wire logic             rstn,        // Asynchronous reset, active low.
    input  wire logic             ce,          // Clock enable; low freezes all state.
    input  wire reg_req_t         req,         // Register access request.
    output logic      [7:0]       reg_rdata,   // Read data, one cycle after rd.
    input  wire logic             sig_energy,  // Input energy seen.
    input  wire logic             cdr_locked,  // Phase loop in lock.
    input  wire logic             eye_ok,      // Eye opening above threshold.
    input  wire logic [7:0]       eq_score,    // Equalizer score, higher better.
    input  wire logic [CNT_W-1:0] vco_count,   // Divided oscillator count.
    input  wire logic             count_done,  // Count valid, one cycle.
    output logic                  count_start, // Start one count, one cycle.
    output logic      [CW-1:0]    vco_coarse,  // Coarse tuning code.
    output logic      [7:0]       vco_div,     // Divide ratio for counting.
    output logic                  datapath_en, // High speed path powered.
    output logic      [7:0]       eq_boost,    // Four two-bit stage boosts.
    output logic                  stage4_limit,// Fourth stage limiting.
    output logic                  dfe_en,      // Feedback equalizer on.
    output logic                  dfe_adapt,   // Feedback adaption running.
    output dfe_tap_t  [NTAPS-1:0] dfe_taps,    // Tap weights and polarities.
    output logic      [7:0]       vod,         // Output swing setting.
    output logic      [7:0]       deemph,      // De-emphasis setting.
    output logic                  sig_det,     // Signal detect status.
    output logic                  lock_det     // Lock detect status.
);

    typedef enum logic [2:0] {
        S_OFF, S_CAL_SET, S_CAL_WAIT, S_EQ_RD, S_EQ_APPLY, S_EQ_WAIT,
        S_LOCK_WAIT, S_LOCKED
    } st_t;

    typedef struct packed {
        st_t                   st;
        logic [7:0]            ctl;
        logic [15:0]           rate;
        logic [7:0]            sub;
        logic [15:0]           ppm;
        logic [7:0]            div;
        logic [7:0]            vod;
        logic [7:0]            de;
        logic [NTAPS-1:0][7:0] taps;
        logic                  eom;
        logic [CW-1:0]         code;
        logic [CW-1:0]         best_code;
        logic [CNT_W-1:0]      best_err;
        logic                  first;
        logic [TAB_AW-1:0]     idx;
        logic [TAB_AW-1:0]     best_idx;
        logic [7:0]            boost;
        logic [7:0]            best_boost;
        logic [7:0]            best_score;
        logic [TMR_W-1:0]      tmr;
        logic [TRY_W-1:0]      tries;
        logic                  go;
        logic [7:0]            rdata;
        logic                  tab_rd;
    } st_all_t;

    localparam logic [CW-1:0]     CODE_MAX = {CW{1'b1}};
    localparam logic [TAB_AW-1:0] IDX_MAX  = TAB_AW'(TAB_N - 1);
    localparam logic [TMR_W-1:0]  T_SET    = TMR_W'(SETTLE_CYC - 1);
    localparam logic [TMR_W-1:0]  T_LOCK   = TMR_W'(LOCK_TMO_CYC - 1);
    localparam logic [TRY_W-1:0]  TRY_LAST = TRY_W'(TRIES - 1);
    localparam st_all_t           ST_RST   = '{st: S_OFF, ctl: CTRL_RST, sub: CFG_RST, eom: EOM_RST, default: '0};

    st_all_t s_q;
    st_all_t s_d;

    logic [7:0]        mem_a;
    logic [7:0]        mem_b;
    logic              tab_hit;
    logic [TAB_AW-1:0] tab_addr;
    logic [2:0]        tap_i;
    logic              tap_hit;
    logic              cdr_rst;
    logic              readapt;
    logic              qual;
    logic [CNT_W-1:0]  target;
    logic [CNT_W-1:0]  err;
    logic              eq_win;

    // Total boost of an entry is the sum of its four stage fields.
    function automatic logic [3:0] boost_sum(input logic [7:0] b);
        boost_sum = 4'(b[1:0]) + 4'(b[3:2]) + 4'(b[5:4]) + 4'(b[7:6]);
    endfunction

    // ----------------------------------------------------------------
    // Decode and datapath terms
    // ----------------------------------------------------------------
    assign tab_hit  = (req.addr >= OFF_TAB) && (req.addr <= OFF_TAB_E);
    assign tab_addr = TAB_AW'(req.addr - OFF_TAB);
    assign tap_hit  = (req.addr >= OFF_TAP0) && (req.addr < OFF_TAP0 + 8'(NTAPS));
    assign tap_i    = 3'(req.addr - OFF_TAP0);
    assign cdr_rst  = req.wr && (req.addr == OFF_CTRL) && req.wdata[B_CDR_RST];
    assign readapt  = req.wr && (req.addr == OFF_CTRL) && req.wdata[B_READAPT];
    // Without the eye monitor only the phase loop qualifies lock.
    assign qual     = cdr_locked && (!s_q.eom || eye_ok);
    // Manual count wins; otherwise the rate count is scaled by subrate.
    assign target   = s_q.sub[B_MANUAL] ? s_q.ppm : (s_q.rate >> s_q.sub[1:0]);
    assign err      = (vco_count >= target) ? vco_count - target : target - vco_count;
    // Ties go to the entry with less total boost.
    assign eq_win   = s_q.first || eq_score > s_q.best_score ||
                      (eq_score == s_q.best_score && boost_sum(s_q.boost) < boost_sum(s_q.best_boost));

    // Software may leave the path forced off whatever the input does.
    assign datapath_en = s_q.ctl[B_SD_OVR] ? s_q.ctl[B_SD_VAL] : sig_energy;

    // ----------------------------------------------------------------
    // Next state: register writes, reads and the acquisition sequence
    // ----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.go     = 1'b0;
        s_d.tab_rd = req.rd && tab_hit;
        // Register writes; pulse bits of control never stick.
        if (req.wr) begin
            case (req.addr)
                OFF_CTRL:   s_d.ctl = req.wdata & CTRL_WMASK;
                OFF_RATE_L: s_d.rate[7:0] = req.wdata;
                OFF_RATE_H: s_d.rate[15:8] = req.wdata;
                OFF_SUB:    s_d.sub = req.wdata;
                OFF_PPM_L:  s_d.ppm[7:0] = req.wdata;
                OFF_PPM_H:  s_d.ppm[15:8] = req.wdata;
                OFF_DIV:    s_d.div = req.wdata;
                OFF_VOD:    s_d.vod = req.wdata;
                OFF_DEEMPH: s_d.de = req.wdata;
                OFF_EOM:    s_d.eom = req.wdata[B_EOM_EN];
                default:    if (tap_hit) s_d.taps[tap_i] = req.wdata & TAP_MASK;
            endcase
        end
        // Register reads; unmapped offsets and reserved bits read zero.
        s_d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                OFF_CTRL:   s_d.rdata = s_q.ctl;
                OFF_STAT:   s_d.rdata = {6'h00, lock_det, sig_det};
                OFF_EQIDX:  s_d.rdata = {3'h0, s_q.best_idx};
                OFF_COARSE: s_d.rdata = 8'(s_q.code);
                OFF_RATE_L: s_d.rdata = s_q.rate[7:0];
                OFF_RATE_H: s_d.rdata = s_q.rate[15:8];
                OFF_SUB:    s_d.rdata = s_q.sub;
                OFF_PPM_L:  s_d.rdata = s_q.ppm[7:0];
                OFF_PPM_H:  s_d.rdata = s_q.ppm[15:8];
                OFF_DIV:    s_d.rdata = s_q.div;
                OFF_VOD:    s_d.rdata = s_q.vod;
                OFF_DEEMPH: s_d.rdata = s_q.de;
                OFF_EOM:    s_d.rdata = {s_q.eom, 7'h00};
                default:    if (tap_hit) s_d.rdata = s_q.taps[tap_i];
            endcase
        end
        // Acquisition sequence.
        case (s_q.st)
            S_OFF: begin
                if (datapath_en) begin
                    s_d.st    = S_CAL_SET;
                    s_d.code  = '0;
                    s_d.first = 1'b1;
                end
            end
            S_CAL_SET: begin
                s_d.go = 1'b1;
                s_d.st = S_CAL_WAIT;
            end
            S_CAL_WAIT: begin
                if (count_done) begin
                    if (s_q.first || err < s_q.best_err) begin
                        s_d.best_err  = err;
                        s_d.best_code = s_q.code;
                    end
                    s_d.first = 1'b0;
                    if (s_q.code == CODE_MAX) begin
                        s_d.code  = s_d.best_code;
                        s_d.st    = S_EQ_RD;
                        s_d.idx   = '0;
                        s_d.first = 1'b1;
                    end else begin
                        s_d.code = s_q.code + 1'b1;
                        s_d.st   = S_CAL_SET;
                    end
                end
            end
            S_EQ_RD:    s_d.st = S_EQ_APPLY;
            S_EQ_APPLY: begin
                s_d.boost = mem_a;
                s_d.tmr   = T_SET;
                s_d.st    = S_EQ_WAIT;
            end
            S_EQ_WAIT: begin
                if (s_q.tmr != '0) begin
                    s_d.tmr = s_q.tmr - 1'b1;
                end else begin
                    if (eq_win) begin
                        s_d.best_score = eq_score;
                        s_d.best_boost = s_q.boost;
                        s_d.best_idx   = s_q.idx;
                    end
                    s_d.first = 1'b0;
                    if (s_q.idx == IDX_MAX) begin
                        s_d.st    = S_LOCK_WAIT;
                        s_d.tmr   = T_LOCK;
                        s_d.boost = s_d.best_boost;
                    end else begin
                        s_d.idx = s_q.idx + 1'b1;
                        s_d.st  = S_EQ_RD;
                    end
                end
            end
            S_LOCK_WAIT: begin
                if (qual) begin
                    s_d.st    = S_LOCKED;
                    s_d.tries = '0;
                end else if (s_q.tmr != '0) begin
                    s_d.tmr = s_q.tmr - 1'b1;
                end else if (s_q.tries == TRY_LAST) begin
                    s_d.st    = S_CAL_SET;
                    s_d.tries = '0;
                    s_d.code  = '0;
                    s_d.first = 1'b1;
                end else begin
                    s_d.tries = s_q.tries + 1'b1;
                    s_d.st    = S_EQ_RD;
                    s_d.idx   = '0;
                    s_d.first = 1'b1;
                end
            end
            S_LOCKED: begin
                // Boost holds here; only loss of lock or a command moves it.
                if (!qual) begin
                    s_d.st    = S_EQ_RD;
                    s_d.idx   = '0;
                    s_d.first = 1'b1;
                end
            end
            default: s_d.st = S_OFF;
        endcase
        // Commands and signal loss override the sequence.
        if (!datapath_en) begin
            s_d.st    = S_OFF;
            s_d.tries = '0;
        end else if (cdr_rst) begin
            s_d.st    = S_CAL_SET;
            s_d.code  = '0;
            s_d.first = 1'b1;
            s_d.tries = '0;
        end else if (readapt && s_q.st != S_OFF) begin
            s_d.st    = S_EQ_RD;
            s_d.idx   = '0;
            s_d.first = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= ST_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Boost setting list
    // ----------------------------------------------------------------
    eq_list_mem #(.N(TAB_N), .AW(TAB_AW), .DW(8)) i_eq_list_mem (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .wr_en   (req.wr && tab_hit),
        .wr_addr (tab_addr),
        .wr_data (req.wdata),
        .ra_addr (s_q.idx),
        .ra_data (mem_a),
        .rb_addr (tab_addr),
        .rb_data (mem_b)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata    = s_q.tab_rd ? mem_b : s_q.rdata;
    assign count_start  = s_q.go;
    assign vco_coarse   = s_q.code;
    assign vco_div      = s_q.sub[B_MANUAL] ? s_q.div : RATE_DIV;
    assign eq_boost     = s_q.boost;
    assign stage4_limit = s_q.ctl[B_LIMIT];
    assign dfe_en       = s_q.ctl[B_DFE_EN];
    // Modes 2 and 3 keep tuning the feedback taps while locked.
    assign dfe_adapt    = dfe_en && s_q.ctl[B_MODE_HI] && s_q.st == S_LOCKED;
    assign vod          = s_q.vod;
    assign deemph       = s_q.de;
    assign sig_det      = datapath_en;
    assign lock_det     = (s_q.st == S_LOCKED);

    // Per-tap fields; every copy of this module owns its own set.
    for (genvar t = 0; t < NTAPS; t++) begin : g_tap
        assign dfe_taps[t] = '{pol: s_q.taps[t][B_TAP_POL], weight: s_q.taps[t][4:0]};
    end

endmodule // chan_adapt_ctrl

/* File: sim/analog_model.sv */
/* Far-side model: phase lock, equalizer score, reference counter.
   Assumes the core clock and reset of the bench. */
`timescale 1ns/10ps
module analog_model
    import retimer_pkg::*;
(
    input  wire logic             clk,         // Core clock.
    input  wire logic             rstn,        // Reset, active low.
    input  wire logic             lock_en,     // Bench lets the loop lock.
    input  wire logic             datapath_en, // Path powered.
    input  wire logic             count_start, // Count request.
    input  wire logic [CW-1:0]    vco_coarse,  // Coarse code.
    input  wire logic [7:0]       eq_boost,    // Stage boosts.
    output logic                  cdr_locked,  // Lock level.
    output logic                  count_done,  // Count answer.
    output logic [CNT_W-1:0]      vco_count,   // Count value.
    output logic [7:0]            eq_score     // Score level.
);
    // Any nonzero boost scores alike, so the tie goes to the lower stage sum.
    assign eq_score   = (eq_boost != 8'h00) ? 8'hc0 : 8'h10;
    assign cdr_locked = lock_en & datapath_en;
    // Count is code times 16; outside a count the value toggles, never stale.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_done <= 1'b0;
            vco_count  <= 16'h0000;
        end else begin
            count_done <= count_start;
            vco_count  <= count_start ? {6'h00, vco_coarse, 4'h0} : ~vco_count;
        end
    end
endmodule // analog_model

/* File: sim/chan_adapt_ctrl_asserts.sv */
/* Port checker for one channel; bound onto chan_adapt_ctrl.
   Assumes one core clock domain. */
`timescale 1ns/10ps
module chan_adapt_ctrl_chk
    import retimer_pkg::*;
#(
    parameter int TRIES = LOCK_TRIES
) (
    input logic       clk,         // Core clock.
    input logic       rstn,        // Reset, active low.
    input logic       ce,          // Clock enable.
    input reg_req_t   req,         // Register request.
    input logic [7:0] reg_rdata,   // Read data.
    input logic       cdr_locked,  // Lock level.
    input logic       count_start, // Count request.
    input logic [7:0] eq_boost,    // Stage boosts.
    input logic       dfe_en,      // Feedback on.
    input logic       dfe_adapt,   // Feedback adapting.
    input logic       datapath_en, // Path powered.
    input logic       sig_det,     // Status.
    input logic       lock_det     // Status.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_lock_up;
        !lock_det ##1 lock_det;
    endsequence
    a_status_mirror: assert property (sig_det == datapath_en) else $error("sig_det differs");
    a_start_pulse: assert property (count_start |=> !count_start) else $error("long start");
    a_no_cal_locked: assert property (count_start |-> !lock_det) else $error("cal in lock");
    a_dfe_gate: assert property (dfe_adapt |-> dfe_en && lock_det) else $error("dfe adapt");
    a_lock_cause: assert property (s_lock_up |-> $past(cdr_locked)) else $error("bad lock");
    a_boost_frozen: assert property (lock_det ##1 lock_det |-> $stable(eq_boost)) else $error("boost moved");
    a_path_drop: assert property (!datapath_en |=> !lock_det) else $error("lock off path");
    a_read_idle: assert property (ce && !req.rd |=> reg_rdata == 8'h00) else $error("stray rdata");
endmodule // chan_adapt_ctrl_chk

/* File: sim/tb_retimer_channel_adapt_ctrl.sv */
/* Bench for one channel: register rows, reset, override, acquisition, eye, loss.
   Assumes analog_model on the far side. */
`timescale 1ns/10ps
module tb_retimer_channel_adapt_ctrl
    import retimer_pkg::*;
;
    logic clk = 0, rstn = 0, ce = 1, sig_energy = 0, eye_ok = 1, lock_en = 1;
    reg_req_t req = '0;
    logic [7:0] reg_rdata, eq_score, vco_div, eq_boost, vod, deemph;
    logic [CNT_W-1:0] vco_count;
    logic [CW-1:0] vco_coarse;
    logic cdr_locked, count_done, count_start, datapath_en, stage4_limit, dfe_en, dfe_adapt, sig_det, lock_det;
    dfe_tap_t [NTAPS-1:0] dfe_taps;
    int num_errors = 0, checked = 0, n;
    // Rows: offset, written, read back. Tap bits 6:5 and status writes drop.
    logic [23:0] rows [5] = '{24'h0a5a5a, 24'h0ba5a5, 24'h10ff9f, 24'h015500, 24'h5fe4e4};
    chan_adapt_ctrl i_chan_adapt_ctrl (.*);
    analog_model i_analog_model (.*);
    initial forever #25 clk = ~clk;
    task chk(input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // One register access; read data lands the cycle after the strobe.
    task acc(input logic w, input logic [7:0] a, d, e);
        @(posedge clk) req <= '{w, !w, a, d};
        @(posedge clk) req <= '0;
        #1;
        if (!w) chk(reg_rdata, e);
    endtask
    // Bounded wait for the lock status to reach a level.
    task wl(input logic v);
        for (int i = 0; i < 4000 && lock_det !== v; i++) @(posedge clk) #1;
        chk(lock_det, v);
    endtask
    task give_verdict;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1;
        foreach (rows[i]) begin
            acc(1, rows[i][23:16], rows[i][15:8], 0);
            acc(0, rows[i][23:16], 0, rows[i][7:0]);
        end
        chk(vod, 8'h5a);
        chk(deemph, 8'ha5);
        chk(dfe_taps[0], 16'h003f);
        chk(vco_div, 8'h01);
        // A write while the clock enable is low must not land.
        @(posedge clk) ce <= 0;
        acc(1, 8'h0a, 8'h33, 0);
        @(posedge clk) ce <= 1;
        chk(vod, 8'h5a);
        @(posedge clk) rstn <= 0;
        repeat (3) @(posedge clk);
        rstn <= 1;
        acc(0, 8'h3e, 0, 8'h80);
        acc(0, 8'h5f, 0, 8'h00);
        acc(1, 8'h00, 8'h11, 0);
        @(posedge clk) sig_energy <= 1;
        @(posedge clk) #1 chk(datapath_en, 0);
        chk(stage4_limit, 1);
        acc(1, 8'h05, 8'h02, 0);
        acc(1, 8'h44, 8'h55, 0);
        acc(1, 8'h49, 8'h03, 0);
        acc(1, 8'h00, 8'h00, 0);
        wl(1);
        acc(0, 8'h03, 0, 8'h20);
        acc(0, 8'h02, 0, 8'h09);
        chk(eq_boost, 8'h03);
        chk(dfe_en, 0);
        acc(1, 8'h00, 8'he0, 0);
        chk(dfe_adapt, 1);
        @(posedge clk) eye_ok <= 0;
        wl(0);
        acc(1, 8'h3e, 8'h00, 0);
        wl(1);
        acc(1, 8'h00, 8'h08, 0);
        chk(lock_det, 0);
        wl(1);
        // Manual target of 336 counts lands on code 21.
        acc(1, 8'h06, 8'h80, 0);
        acc(1, 8'h07, 8'h50, 0);
        acc(1, 8'h08, 8'h01, 0);
        acc(1, 8'h09, 8'h07, 0);
        chk(vco_div, 8'h07);
        acc(1, 8'h00, 8'h04, 0);
        chk(lock_det, 0);
        wl(1);
        acc(0, 8'h03, 0, 8'h15);
        chk(vco_coarse, 8'h15);
        // Four failed attempts must pass before calibration starts again.
        @(posedge clk) lock_en <= 0;
        for (n = 0; n < 4000 && count_start !== 1; n++) @(posedge clk) #1;
        chk(count_start, 1);
        chk(n >= 4 * (TAB_N * (SETTLE_CYC + 2) + LOCK_TMO_CYC), 1);
        @(posedge clk) lock_en <= 1;
        wl(1);
        @(posedge clk) sig_energy <= 0;
        repeat (2) @(posedge clk) #1;
        chk(datapath_en, 0);
        chk(lock_det, 0);
        give_verdict;
    end
endmodule // tb_retimer_channel_adapt_ctrl
bind chan_adapt_ctrl chan_adapt_ctrl_chk #(.TRIES(TRIES)) i_chan_adapt_ctrl_chk (.*);
